// ===== pkg/dac_serial_regs.vh
// constants for the quad converter serial load control
`ifndef DAC_SERIAL_REGS_VH
`define DAC_SERIAL_REGS_VH
`define WORD_BITS        12
`define CODE_BITS        8
`define BIT_ALL_SLEEP    11
`define BIT_SEL_SLEEP    10
`define BIT_SEL_HI       9
`define BIT_SEL_LO       8
`define CODE_MSB         7
`define CODE_LSB         0
`define CHANNELS         4
`define SEL_BITS         2
`define CODE_ZERO        8'h00
`define SYNC_ZERO        3'h0
`endif

// ===== core/pin_sync.v
// three-stage synchroniser with agreement filter for one pin
module pin_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  input  wire i_clock,
  input  wire i_nrst,
  input  wire i_pin,
  output reg  o_level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  // first stage feeds only the second
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_ff   <= RESET_LEVEL;
      s2_ff   <= RESET_LEVEL;
      s3_ff   <= RESET_LEVEL;
      o_level <= RESET_LEVEL;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_level <= s3_ff;
      end
    end
  end
endmodule

// ===== core/dac_serial_ctrl.v
// serial load control of a quad 8-bit voltage-output converter
`include "dac_serial_regs.vh"
//
// Contract
// - 12-bit word MSB first: all sleep, selected sleep, two select bits, 8-bit code.
// - all-channel sleep bit low powers down every channel, outputs high impedance.
// - selected sleep bit low powers down only the addressed channel.
// - code bits go into exactly one input register, the selected one.
// - select 00 is A, 01 B, 10 C, 11 D; high bit first.
// - chip select rising, clock low, strobe and clear high: update addressed register.
// - chip select high and strobe low: all input registers copied to output registers.
// - strobe is level sensitive; output registers follow while low, hold when high. The code follows only while chip select is also high.
// - chip select low: shift one bit per serial clock rise; ignore edges otherwise.
// - clear low zeroes input and output registers; shifter untouched.
module dac_serial_ctrl #(
  parameter WORD_BITS = `WORD_BITS,
  parameter CODE_BITS = `CODE_BITS,
  parameter CHANNELS  = `CHANNELS
) (
  input  wire                           i_clock,
  input  wire                           i_nrst,
  input  wire                           i_serial_clk,
  input  wire                           i_chip_select_n,
  input  wire                           i_serial_in_or_sleep,
  input  wire                           i_output_update_strobe_n,
  input  wire                           i_zero_all_n,
  output reg  [CHANNELS*CODE_BITS-1:0]  o_input_regs,
  output reg  [CHANNELS*CODE_BITS-1:0]  o_dac_regs,
  output reg  [CHANNELS-1:0]            o_channel_awake,
  output reg  [CHANNELS-1:0]            o_out_enable_n,
  output reg  [WORD_BITS-1:0]           o_serial_word_shifter
);
  // ==========================================================
  // local sizes
  localparam SEL_BITS  = `SEL_BITS;
  localparam BANK_BITS = CHANNELS * CODE_BITS;

  // ==========================================================
  // helper functions
  // one-hot lane mask from the select pair, channel a in bit 0
  function [CHANNELS-1:0] chan_mask;
    input [SEL_BITS-1:0] sel_in;
    chan_mask = {{(CHANNELS-1){1'b0}}, 1'b1} << sel_in;
  endfunction

  // awake pattern a transferred word leaves behind; a word for one channel
  // also wakes the others unless its all-sleep bit is low, so a stray all-sleep is undone by any later word with that bit high
  function [CHANNELS-1:0] awake_after;
    input                all_on;
    input                sel_on;
    input [CHANNELS-1:0] mask_in;
    if (!all_on) begin
      awake_after = {CHANNELS{1'b0}};
    end else begin
      awake_after = (~mask_in) | (mask_in & {CHANNELS{sel_on}});
    end
  endfunction

  // input bank with the masked lane replaced by a new code
  function [BANK_BITS-1:0] bank_write;
    input [BANK_BITS-1:0] bank;
    input [CHANNELS-1:0]  mask_in;
    input [CODE_BITS-1:0] code_in;
    integer k;
    begin
      bank_write = bank;
      for (k = 0; k < CHANNELS; k = k + 1) begin
        if (mask_in[k]) begin
          bank_write[k*CODE_BITS +: CODE_BITS] = code_in;
        end
      end
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  // every pin is asynchronous, so each passes four flip-flops, three stages and the filter; the price
  // is four to five clocks of lag on every event
  wire sclk;
  wire cs_n;
  wire sdi;
  wire ld_n;
  wire clr_n;

  pin_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sclk (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_pin   (i_serial_clk),
    .o_level (sclk)
  );

  pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_cs (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_pin   (i_chip_select_n),
    .o_level (cs_n)
  );

  pin_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sdi (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_pin   (i_serial_in_or_sleep),
    .o_level (sdi)
  );

  pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_ld (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_pin   (i_output_update_strobe_n),
    .o_level (ld_n)
  );

  pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_clr (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_pin   (i_zero_all_n),
    .o_level (clr_n)
  );

  // ==========================================================
  // edge detect
  // reset values match the idle pin levels so no false edge follows reset
  reg  sclk_d_ff;
  reg  cs_d_ff;
  wire sclk_rise;
  wire cs_rise;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff <= sclk;
      cs_d_ff   <= cs_n;
    end
  end

  assign sclk_rise = sclk & ~sclk_d_ff;
  assign cs_rise   = cs_n & ~cs_d_ff;

  // ==========================================================
  // serial word shifter
  // clear does not reach here, so a word in flight survives a clear
  reg [WORD_BITS-1:0] nxt_shifter;

  always @* begin
    nxt_shifter = o_serial_word_shifter;
    if (!cs_n && sclk_rise) begin
      nxt_shifter = {o_serial_word_shifter[WORD_BITS-2:0], sdi};
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serial_word_shifter <= {WORD_BITS{1'b0}};
    end else begin
      o_serial_word_shifter <= nxt_shifter;
    end
  end

  // ==========================================================
  // word fields
  wire                 all_on;
  wire                 sel_on;
  wire [SEL_BITS-1:0]  sel;
  wire [CODE_BITS-1:0] code;
  wire [CHANNELS-1:0]  mask;
  wire                 take;
  wire                 load_level;

  assign all_on     = o_serial_word_shifter[`BIT_ALL_SLEEP];
  assign sel_on     = o_serial_word_shifter[`BIT_SEL_SLEEP];
  assign sel        = {o_serial_word_shifter[`BIT_SEL_HI], o_serial_word_shifter[`BIT_SEL_LO]};
  assign code       = o_serial_word_shifter[`CODE_MSB:`CODE_LSB];
  assign mask       = chan_mask(sel);
  // select rise is refused while the serial clock is high, the strobe low or clear low
  assign take       = cs_rise & ~sclk & ld_n & clr_n;
  assign load_level = cs_n & ~ld_n;

  // ==========================================================
  // next register contents
  // clear acts on the filtered level, so it lands a few clocks late but never on a glitch
  reg [BANK_BITS-1:0] nxt_input;
  reg [BANK_BITS-1:0] nxt_dac;
  reg [CHANNELS-1:0]  nxt_awake;

  always @* begin
    nxt_input = o_input_regs;
    if (!clr_n) begin
      nxt_input = {BANK_BITS{1'b0}};
    end else if (take) begin
      nxt_input = bank_write(o_input_regs, mask, code);
    end
  end

  always @* begin
    nxt_dac = o_dac_regs;
    if (!clr_n) begin
      nxt_dac = {BANK_BITS{1'b0}};
    end else if (load_level) begin
      nxt_dac = o_input_regs;
    end
  end

  always @* begin
    nxt_awake = o_channel_awake;
    if (take) begin
      nxt_awake = awake_after(all_on, sel_on, mask);
    end
  end

  // ==========================================================
  // registers
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_input_regs <= {BANK_BITS{1'b0}};
      o_dac_regs   <= {BANK_BITS{1'b0}};
    end else begin
      o_input_regs <= nxt_input;
      o_dac_regs   <= nxt_dac;
    end
  end

  // the enable is registered beside the awake bit rather than decoded from it,
  // so both change on the same edge with no decode glitch on the pin
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_channel_awake <= {CHANNELS{1'b1}};
      o_out_enable_n  <= {CHANNELS{1'b0}};
    end else begin
      o_channel_awake <= nxt_awake;
      o_out_enable_n  <= ~nxt_awake;
    end
  end
endmodule

// ===== tb/dac_serial_ctrl_properties.sv
// port assertions for the serial load control
module dac_serial_ctrl_properties (input i_clock, i_nrst, i_serial_clk, i_chip_select_n, i_serial_in_or_sleep,
  i_output_update_strobe_n, i_zero_all_n, input [31:0] o_input_regs, o_dac_regs,
  input [3:0] o_channel_awake, o_out_enable_n, input [11:0] o_serial_word_shifter);
  timeunit 1ns; timeprecision 100ps;
  // windows of 8 cover the pin synchroniser lag
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  oe_inv_a: assert property (o_out_enable_n == ~o_channel_awake) else $error("oe");
  clr_zero_a: assert property ((!i_zero_all_n) [*8] |-> !o_input_regs && !o_dac_regs) else $error("clr");
  dac_hold_a: assert property ((i_output_update_strobe_n && i_zero_all_n) [*8] |=> $stable(o_dac_regs))
    else $error("hold");
  dac_follow_a: assert property ((i_chip_select_n && !i_output_update_strobe_n && i_zero_all_n) [*8]
    ##0 $stable(o_input_regs) |-> o_dac_regs == o_input_regs) else $error("load");
  cs_idle_a: assert property ((i_chip_select_n) [*8] |=> $stable(o_serial_word_shifter)) else $error("cs");
  clk_low_a: assert property ((!i_serial_clk) [*8] |=> $stable(o_serial_word_shifter)) else $error("clk");
  reg_hold_a: assert property ((!i_chip_select_n && i_zero_all_n) [*8] |=> $stable(o_input_regs)) else $error("reg");
  wake_hold_a: assert property ((!i_chip_select_n) [*8] |=> $stable(o_channel_awake)) else $error("wake");
endmodule
bind dac_serial_ctrl dac_serial_ctrl_properties chk (.*);

// ===== tb/serial_host_model.sv
// host that shifts words into the serial pins
module serial_host_model (output logic o_sclk = 0, o_cs_n = 1, o_sdi = 0);
  timeunit 1ns; timeprecision 100ps;
  task automatic send(input logic [11:0] w);
    o_cs_n = 0; #100;
    for (int i = 11; i >= 0; i--) begin
      o_sdi = w[i]; #62.5 o_sclk = 1; #62.5 o_sclk = 0;
    end
    // clock parks low before select rises; released data shows the inverse
    #100 o_cs_n = 1; o_sdi = ~w[0]; #200;
  endtask
endmodule

// ===== tb/quad_dac_serial_load_control_bench.sv
// self-checking bench for the serial load control
module quad_dac_serial_load_control_bench;
  timeunit 1ns; timeprecision 100ps;
  logic i_clock = 0, i_nrst = 0, i_output_update_strobe_n = 1, i_zero_all_n = 1;
  logic i_serial_clk, i_chip_select_n, i_serial_in_or_sleep;
  logic [31:0] o_input_regs, o_dac_regs, ei = 0, ed = 0;
  logic [3:0] o_channel_awake, o_out_enable_n, ea = 4'hf;
  logic [11:0] o_serial_word_shifter, w = 0;
  logic [83:0] q[$];
  int err_count = 0, num_checks = 0;
  event got;
  always #4 i_clock = ~i_clock;
  serial_host_model host (.o_sclk(i_serial_clk), .o_cs_n(i_chip_select_n), .o_sdi(i_serial_in_or_sleep));
  dac_serial_ctrl dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_serial_clk(i_serial_clk),
    .i_chip_select_n(i_chip_select_n), .i_serial_in_or_sleep(i_serial_in_or_sleep),
    .i_output_update_strobe_n(i_output_update_strobe_n), .i_zero_all_n(i_zero_all_n),
    .o_input_regs(o_input_regs), .o_dac_regs(o_dac_regs), .o_channel_awake(o_channel_awake),
    .o_out_enable_n(o_out_enable_n), .o_serial_word_shifter(o_serial_word_shifter));
  task automatic note(); q.push_back({ei, ed, ea, ~ea, w}); repeat (12) @(posedge i_clock); #1 ->got; endtask
  task automatic cmp(input logic [83:0] e, s);
    num_checks++;
    if (s !== e) begin err_count++; $display("[FAIL] regs expected %h seen %h", e, s); end
  endtask
  always @(got) cmp(q.pop_front(), {o_input_regs, o_dac_regs, o_channel_awake, o_out_enable_n,
    o_serial_word_shifter});
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h710071cb));
    #21 i_nrst = 1;
    #40;
    for (int i = 0; i < 12; i++) begin
      w = 12'($urandom);
      w[11:10] = {i % 3 != 0, i[2]};
      w[9:8] = i[1:0];
      host.send(w);
      ei[w[9:8]*8+:8] = w[7:0];
      ea = w[11] ? ~(4'h1 << w[9:8]) | {3'h0, w[10]} << w[9:8] : 4'h0;
      note();
      if (i[0]) begin i_output_update_strobe_n = 0; ed = ei; note(); end
      i_output_update_strobe_n = 1;
    end
    i_zero_all_n = 0; ei = 0; ed = 0; note();
    i_zero_all_n = 1; note(); finish_test();
  end
endmodule
